//--- uart_rx_dma_channel_tb.sv
// self-checking bench for the uart receive dma channel
`timescale 1ns/100ps
module uart_rx_dma_channel_tb;
  import urd_pkg::*;
  localparam int BB = 4;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   awa = 8'h00;
  logic [7:0]   ara = 8'h00;
  logic [31:0]  wd = 32'h0;
  logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic         go = 1'b0, err = 1'b0, ovr = 1'b0, sof = 1'b0;
  logic         xw = 1'b0, xv = 1'b1;
  logic         awr, wrd, bv, arr, rv, uv, ur, irq;
  logic [1:0]   bresp, rresp, lr;
  logic [31:0]  rdat, rdv;
  logic [7:0]   ub;
  urd_mem_wr_s  mw;
  urd_desc_wr_s dw, ld;
  logic [7:0]   dq[$];
  logic [6:0]   ea = 7'h0;
  logic [2:0]   ee = 3'h5;
  logic         ey = 1'b0;
  int           err_count = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  initial forever #2.5 clk = ~clk;
  urd_rx_dma #(.BUF_BYTES(BB)) dut (
    .ref_clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .uart_byte_i(ub), .uart_valid_i(uv), .uart_ready_o(ur),
    .uart_err_i(err), .uart_ovr_i(ovr), .sof_i(sof),
    .bmgr_sel_wr_i(xw), .bmgr_sel_i(xv),
    .mem_wr_o(mw), .desc_wr_o(dw), .irq_o(irq));
  urd_src_model src (.clk_i(clk), .go_i(go), .rdy_i(ur),
    .byte_o(ub), .valid_o(uv));
  // ****************************
  // shared tasks
  // ****************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // definition readback: written byte with the direction bit forced
  function automatic logic [31:0] def_exp(input logic [7:0] d);
    return {24'h0, d | (8'h01 << DIR_BIT)};
  endfunction : def_exp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    @(posedge clk);
    while (awr !== 1'b1) @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    while (bv !== 1'b1) @(posedge clk);
    br <= 1'b0;
    lr = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(posedge clk);
    while (arr !== 1'b1) @(posedge clk);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    rr <= 1'b0;
    rdv = rdat;
    lr = rresp;
  endtask : rd
  task automatic send(input int n);
    int t;
    t = 0;
    @(posedge clk);
    go <= 1'b1;
    while (t < n) begin
      @(posedge clk);
      if (uv === 1'b1 && ur === 1'b1) t++;
    end
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : send
  // k: 0 frame pulse, 1 error, 2 overrun, 3 buffer manager select
  task automatic pl(input int k);
    @(posedge clk);
    {xw, ovr, err, sof} <= 4'h1 << k;
    @(posedge clk);
    {xw, ovr, err, sof} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask : pl
  task automatic start(input logic [7:0] d);
    ee = d[2:0];
    wr(DEF_OFS, d);
    rd(DEF_OFS);
    ey = rdv[4];
  endtask : start
  // ****************************
  // output monitor and timeout
  // ****************************
  always @(posedge clk) begin
    if (mw.valid === 1'b1) begin
      chk(mw.addr, ea, "buffer address");
      chk(mw.buf_y, ey, "buffer select");
      chk(mw.dset, ee, "descriptor set");
      chk(mw.data, dq.pop_front(), "byte");
      ea = ea + 7'h1;
    end
    if (dw.valid === 1'b1) begin
      chk(dw.count, ea, "descriptor count");
      chk(dw.buf_y, ey, "descriptor buffer");
      chk(dw.dset, ee, "descriptor update set");
      ld = dw;
      ea = 7'h0;
      ey = ~ey;
    end
    if (uv === 1'b1 && ur === 1'b1) dq.push_back(ub);
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      final_report();
    end
  end
  // ****************************
  // main sequence
  // ****************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(DEF_OFS);
    chk(rdv, {24'h0, DEF_RST}, "definition reset");
    rd(STS_OFS);
    chk(rdv, 32'h0, "status reset");
    rd(8'h10);
    chk(lr, RESP_ERR, "unmapped read");
    wr(8'h10, 8'hff);
    chk(lr, RESP_ERR, "unmapped write");
    wr(DEF_OFS, 8'h20);
    rd(DEF_OFS);
    chk(rdv, def_exp(8'h20), "direction bit");
    wr(IMSK_OFS, 8'h03);
    start(8'he5);
    chk(rdv, def_exp(8'he5), "definition readback");
    send(2 * BB);
    chk(irq, 1'b1, "buffer interrupt");
    rd(IST_OFS);
    chk(rdv[1], 1'b1, "buffer filled status");
    wr(IST_OFS, 8'h03);
    chk(irq, 1'b0, "interrupt cleared");
    pl(3);
    rd(DEF_OFS);
    chk(rdv[4], 1'b1, "manager select");
    ey = 1'b1;
    send(1);
    wr(STS_OFS, 8'h88);
    send(1);
    pl(0);
    rd(DEF_OFS);
    chk(rdv[7], 1'b1, "first frame no expiry");
    pl(0);
    rd(DEF_OFS);
    chk(rdv[7], 1'b0, "run cleared on timeout");
    chk(irq, 1'b1, "timeout interrupt");
    chk(ld.nak_clr, 1'b1, "nak cleared");
    chk(ld.count, 7'h2, "halt count");
    rd(STS_OFS);
    chk(rdv[1], 1'b1, "timeout flag");
    wr(STS_OFS, 8'h88);
    rd(STS_OFS);
    chk(rdv[1], 1'b1, "zero write keeps flag");
    wr(STS_OFS, 8'h8a);
    rd(STS_OFS);
    chk(rdv[1], 1'b0, "one write clears flag");
    wr(IST_OFS, 8'h03);
    wr(STS_OFS, 8'h00);
    start(8'he2);
    send(1);
    pl(1);
    rd(DEF_OFS);
    chk(rdv[7], 1'b0, "run cleared on error");
    chk(irq, 1'b0, "no error interrupt");
    chk(ld.count, 7'h1, "error count");
    wr(STS_OFS, 8'h80);
    start(8'ha2);
    send(1);
    pl(0);
    rd(DEF_OFS);
    chk(rdv[7], 1'b1, "stays running");
    chk(irq, 1'b0, "masked by enable");
    rd(STS_OFS);
    chk(rdv[1:0], 2'b10, "timeout without overrun");
    pl(2);
    rd(DEF_OFS);
    chk(rdv[7], 1'b1, "overrun keeps running");
    rd(STS_OFS);
    chk(rdv[1:0], 2'b11, "overrun flags");
    wr(DEF_OFS, 8'h22);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "stop without enable");
    final_report();
  end
endmodule : uart_rx_dma_channel_tb

//--- urd_pkg.sv
// shared constants and types for the uart receive dma channel
package urd_pkg;
  // *****************************
  // register map (byte offsets)
  // *****************************
  localparam logic [7:0] DEF_OFS  = 8'h00;
  localparam logic [7:0] STS_OFS  = 8'h04;
  localparam logic [7:0] IST_OFS  = 8'h08;
  localparam logic [7:0] IMSK_OFS = 8'h0c;
  // *****************************
  // field positions
  // *****************************
  localparam int DSET_LSB  = 0;
  localparam int DSET_W    = 3;
  localparam int DIR_BIT   = 3;
  localparam int SEL_BIT   = 4;
  localparam int CONT_BIT  = 5;
  localparam int IRQEN_BIT = 6;
  localparam int EN_BIT    = 7;
  localparam int OVF_BIT   = 0;
  localparam int TOF_BIT   = 1;
  localparam int TMO_LSB   = 2;
  localparam int TMO_W     = 5;
  localparam int TMEN_BIT  = 7;
  localparam int IRQ_W   = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BUF  = 1;
  localparam int CW      = 7;
  // *****************************
  // reset values and answers
  // *****************************
  localparam logic [7:0] DEF_RST  = 8'h08;
  localparam logic [7:0] STS_RST  = 8'h00;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // *****************************
  // types
  // *****************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } urd_state_e;
  typedef struct packed {
    logic              valid;
    logic [DSET_W-1:0] dset;
    logic              buf_y;
    logic [CW-1:0]     addr;
    logic [7:0]        data;
  } urd_mem_wr_s;
  typedef struct packed {
    logic              valid;
    logic [DSET_W-1:0] dset;
    logic              buf_y;
    logic [CW-1:0]     count;
    logic              nak_clr;
  } urd_desc_wr_s;
endpackage : urd_pkg

//--- urd_rx_dma.sv
// uart receive dma channel with axi4-lite register slave
`timescale 1ns/100ps
module urd_rx_dma
  import urd_pkg::*;
#(
  parameter int BUF_BYTES = 64
) (
  input  wire logic         ref_clk_i,       // 200 mhz clock
  input  wire logic         sys_rst_i,       // sync reset, high
  input  wire logic [7:0]   s_axi_awaddr_i,  // write address
  input  wire logic         s_axi_awvalid_i, // write address valid
  output logic              s_axi_awready_o, // write address ready
  input  wire logic [31:0]  s_axi_wdata_i,   // write data
  input  wire logic [3:0]   s_axi_wstrb_i,   // write strobes
  input  wire logic         s_axi_wvalid_i,  // write data valid
  output logic              s_axi_wready_o,  // write data ready
  output logic [1:0]        s_axi_bresp_o,   // write response
  output logic              s_axi_bvalid_o,  // write response valid
  input  wire logic         s_axi_bready_i,  // write response ready
  input  wire logic [7:0]   s_axi_araddr_i,  // read address
  input  wire logic         s_axi_arvalid_i, // read address valid
  output logic              s_axi_arready_o, // read address ready
  output logic [31:0]       s_axi_rdata_o,   // read data
  output logic [1:0]        s_axi_rresp_o,   // read response
  output logic              s_axi_rvalid_o,  // read data valid
  input  wire logic         s_axi_rready_i,  // read data ready
  input  wire logic [7:0]   uart_byte_i,     // received byte
  input  wire logic         uart_valid_i,    // byte available
  output logic              uart_ready_o,    // byte taken
  input  wire logic         uart_err_i,      // receiver error pulse
  input  wire logic         uart_ovr_i,      // overrun pulse
  input  wire logic         sof_i,           // 1 ms frame pulse
  input  wire logic         bmgr_sel_wr_i,   // buffer manager sets select
  input  wire logic         bmgr_sel_i,      // new buffer select
  output urd_mem_wr_s       mem_wr_o,        // byte write to buffer
  output urd_desc_wr_s      desc_wr_o,       // descriptor update
  output logic              irq_o            // level interrupt
);
  localparam logic [CW-1:0] BUF_LAST = CW'(BUF_BYTES - 1);

  // *****************************
  // state
  // *****************************
  urd_state_e         st_r, st_nxt;
  logic [7:0]         def_r, def_nxt;
  logic [7:0]         sts_r, sts_nxt;
  logic [IRQ_W-1:0]   ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic [CW-1:0]      bc_r, bc_nxt;
  logic [TMO_W-1:0]   tmo_r, tmo_nxt;
  logic               armed_r, armed_nxt;
  logic               aw_r, aw_nxt, b_r, b_nxt;
  logic               ar_r, ar_nxt, rv_r, rv_nxt;
  logic [1:0]         bres_r, bres_nxt, rres_r, rres_nxt;
  logic [31:0]        rd_r, rd_nxt;
  logic               rdy_r, rdy_nxt, irq_r, irq_nxt;
  urd_mem_wr_s        mem_r, mem_nxt;
  urd_desc_wr_s       desc_r, desc_nxt;
  logic               wr_go, rd_go, byte_go, buf_end;
  logic               tmo_evt, ovr_evt, err_evt, halt, soft_end;
  logic               irq_en;
  logic [7:0]         wd;
  logic [CW-1:0]      bc_inc;

  // *****************************
  // next-state logic
  // *****************************
  always_comb begin
    st_nxt    = st_r;
    def_nxt   = def_r;
    sts_nxt   = sts_r;
    ist_nxt   = ist_r;
    imsk_nxt  = imsk_r;
    bc_nxt    = bc_r;
    tmo_nxt   = tmo_r;
    armed_nxt = armed_r;
    aw_nxt    = 1'b0;
    ar_nxt    = 1'b0;
    b_nxt     = b_r;
    bres_nxt  = bres_r;
    rv_nxt    = rv_r;
    rres_nxt  = rres_r;
    rd_nxt    = rd_r;
    mem_nxt   = '0;
    desc_nxt  = '0;
    irq_en    = def_r[IRQEN_BIT];
    wd        = s_axi_wdata_i[7:0];
    wr_go     = aw_r && s_axi_awvalid_i && s_axi_wvalid_i;
    rd_go     = ar_r && s_axi_arvalid_i;
    byte_go   = rdy_r && uart_valid_i;
    bc_inc    = bc_r + CW'(byte_go);
    err_evt   = (st_r == ST_RUN) && uart_err_i;
    ovr_evt   = (st_r == ST_RUN) && uart_ovr_i;
    tmo_evt   = (st_r == ST_RUN) && sof_i && armed_r && !byte_go &&
                sts_r[TMEN_BIT] && (tmo_r <= TMO_W'(1));
    buf_end   = byte_go && (bc_r == BUF_LAST);
    soft_end  = (tmo_evt || ovr_evt) && !irq_en;
    halt      = err_evt || ((tmo_evt || ovr_evt) && irq_en);
    // axi handshakes, address and data taken together
    if (s_axi_awvalid_i && s_axi_wvalid_i && !aw_r && !b_r)
      aw_nxt = 1'b1;
    if (s_axi_arvalid_i && !ar_r && !rv_r)
      ar_nxt = 1'b1;
    if (b_r && s_axi_bready_i)
      b_nxt = 1'b0;
    if (rv_r && s_axi_rready_i)
      rv_nxt = 1'b0;
    // software writes
    if (wr_go) begin
      b_nxt    = 1'b1;
      bres_nxt = RESP_OK;
      if (s_axi_wstrb_i[0]) begin
        case (s_axi_awaddr_i)
          DEF_OFS:  def_nxt = wd;
          STS_OFS: begin
            sts_nxt[TMEN_BIT] = wd[TMEN_BIT];
            sts_nxt[TMO_LSB +: TMO_W] = wd[TMO_LSB +: TMO_W];
            sts_nxt[OVF_BIT] = sts_r[OVF_BIT] && !wd[OVF_BIT];
            sts_nxt[TOF_BIT] = sts_r[TOF_BIT] && !wd[TOF_BIT];
          end
          IST_OFS:  ist_nxt  = ist_r & ~wd[IRQ_W-1:0];
          IMSK_OFS: imsk_nxt = wd[IRQ_W-1:0];
          default:  bres_nxt = RESP_ERR;
        endcase
      end
    end
    // channel engine
    case (st_r)
      ST_IDLE: begin
        if (def_r[EN_BIT]) begin
          st_nxt    = ST_RUN;
          bc_nxt    = '0;
          armed_nxt = 1'b0;
        end
      end
      ST_RUN: begin
        if (byte_go) begin
          mem_nxt.valid = 1'b1;
          mem_nxt.dset  = def_r[DSET_LSB +: DSET_W];
          mem_nxt.buf_y = def_r[SEL_BIT];
          mem_nxt.addr  = bc_r;
          mem_nxt.data  = uart_byte_i;
          bc_nxt        = bc_inc;
          tmo_nxt       = sts_r[TMO_LSB +: TMO_W];
          armed_nxt     = 1'b1;
        end else if (sof_i && armed_r && sts_r[TMEN_BIT] &&
                     tmo_r != '0) begin
          tmo_nxt = tmo_r - TMO_W'(1);
        end
        if (tmo_evt || ovr_evt)
          sts_nxt[TOF_BIT] = 1'b1;
        if (ovr_evt)
          sts_nxt[OVF_BIT] = 1'b1;
        if (halt || soft_end || buf_end) begin
          desc_nxt.valid   = 1'b1;
          desc_nxt.dset    = def_r[DSET_LSB +: DSET_W];
          desc_nxt.buf_y   = def_r[SEL_BIT];
          desc_nxt.count   = buf_end ? CW'(BUF_BYTES) : bc_inc;
          desc_nxt.nak_clr = 1'b1;
          bc_nxt           = '0;
          armed_nxt        = 1'b0;
          def_nxt[SEL_BIT] = !def_r[SEL_BIT];
          if (buf_end)
            ist_nxt[IRQ_BUF] = 1'b1;
        end
        if (halt) begin
          def_nxt[EN_BIT] = 1'b0;
          st_nxt          = ST_IDLE;
        end else if (!def_nxt[EN_BIT]) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (bmgr_sel_wr_i)
      def_nxt[SEL_BIT] = bmgr_sel_i;
    def_nxt[DIR_BIT] = 1'b1;
    if (def_r[EN_BIT] && !def_nxt[EN_BIT] && irq_en && !err_evt)
      ist_nxt[IRQ_DONE] = 1'b1;
    // reads
    if (rd_go) begin
      rv_nxt   = 1'b1;
      rres_nxt = RESP_OK;
      case (s_axi_araddr_i)
        DEF_OFS:  rd_nxt = {24'h0, def_r};
        STS_OFS:  rd_nxt = {24'h0, sts_r};
        IST_OFS:  rd_nxt = {{(32-IRQ_W){1'b0}}, ist_r};
        IMSK_OFS: rd_nxt = {{(32-IRQ_W){1'b0}}, imsk_r};
        default: begin
          rd_nxt   = 32'h0;
          rres_nxt = RESP_ERR;
        end
      endcase
    end
    rdy_nxt = (st_nxt == ST_RUN) && !halt;
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  // *****************************
  // registers
  // *****************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r    <= ST_IDLE;
      def_r   <= DEF_RST;
      sts_r   <= STS_RST;
      ist_r   <= '0;
      imsk_r  <= '0;
      bc_r    <= '0;
      tmo_r   <= '0;
      armed_r <= 1'b0;
      aw_r    <= 1'b0;
      ar_r    <= 1'b0;
      b_r     <= 1'b0;
      bres_r  <= RESP_OK;
      rv_r    <= 1'b0;
      rres_r  <= RESP_OK;
      rd_r    <= '0;
      rdy_r   <= 1'b0;
      irq_r   <= 1'b0;
      mem_r   <= '0;
      desc_r  <= '0;
    end else begin
      st_r    <= st_nxt;
      def_r   <= def_nxt;
      sts_r   <= sts_nxt;
      ist_r   <= ist_nxt;
      imsk_r  <= imsk_nxt;
      bc_r    <= bc_nxt;
      tmo_r   <= tmo_nxt;
      armed_r <= armed_nxt;
      aw_r    <= aw_nxt;
      ar_r    <= ar_nxt;
      b_r     <= b_nxt;
      bres_r  <= bres_nxt;
      rv_r    <= rv_nxt;
      rres_r  <= rres_nxt;
      rd_r    <= rd_nxt;
      rdy_r   <= rdy_nxt;
      irq_r   <= irq_nxt;
      mem_r   <= mem_nxt;
      desc_r  <= desc_nxt;
    end
  end

  assign s_axi_awready_o = aw_r;
  assign s_axi_wready_o  = aw_r;
  assign s_axi_bvalid_o  = b_r;
  assign s_axi_bresp_o   = bres_r;
  assign s_axi_arready_o = ar_r;
  assign s_axi_rvalid_o  = rv_r;
  assign s_axi_rresp_o   = rres_r;
  assign s_axi_rdata_o   = rd_r;
  assign uart_ready_o    = rdy_r;
  assign mem_wr_o        = mem_r;
  assign desc_wr_o       = desc_r;
  assign irq_o           = irq_r;

  // *****************************
  // assertions
  // *****************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_halted;
    !def_r[EN_BIT] ##0 desc_r.valid ##0 desc_r.nak_clr;
  endsequence

  a_err_halts: assert property (err_evt |=> s_halted)
    else $error("error did not halt channel");
  a_err_no_irq: assert property (
    err_evt && !ist_r[IRQ_DONE] |=> !ist_r[IRQ_DONE])
    else $error("uart error raised interrupt");
  a_tmo_halts: assert property (
    tmo_evt && irq_en && !err_evt |=> s_halted ##0 ist_r[IRQ_DONE])
    else $error("time-out halt incomplete");
  a_tmo_stays: assert property (
    soft_end && !err_evt && !wr_go |=> def_r[EN_BIT] && sts_r[TOF_BIT])
    else $error("channel stopped with interrupts off");
  a_fall_irq: assert property (
    $rose(ist_r[IRQ_DONE]) |-> $past(irq_en) && $fell(def_r[EN_BIT]))
    else $error("done interrupt without enabled fall");
  a_flag_keep: assert property (
    sts_r[TOF_BIT] && !(wr_go && s_axi_awaddr_i == STS_OFS &&
    s_axi_wstrb_i[0] && wd[TOF_BIT]) |=> sts_r[TOF_BIT])
    else $error("time-out flag lost");
  a_dir_one: assert property (def_r[DIR_BIT])
    else $error("direction bit not one");
  a_sel_swap: assert property (
    buf_end && !bmgr_sel_wr_i && !wr_go |=>
    def_r[SEL_BIT] != $past(def_r[SEL_BIT]))
    else $error("buffer did not alternate");
  a_mem_tgt: assert property (
    byte_go |=> mem_r.valid && mem_r.buf_y == $past(def_r[SEL_BIT]) &&
    mem_r.dset == $past(def_r[DSET_LSB +: DSET_W]))
    else $error("byte written to wrong buffer");
  a_tmo_reload: assert property (
    byte_go |=> tmo_r == $past(sts_r[TMO_LSB +: TMO_W]))
    else $error("time-out not reloaded");
endmodule : urd_rx_dma

//--- urd_src_model.sv
// uart receiver model offering bytes to the channel
`timescale 1ns/100ps
module urd_src_model (
  input  wire logic       clk_i,   // clock
  input  wire logic       go_i,    // keep offering bytes
  input  wire logic       rdy_i,   // channel ready
  output logic [7:0]      byte_o,  // byte offered
  output logic            valid_o  // byte valid
);
  integer     seed    = 32'h5505;
  logic [7:0] byte_r  = 8'h00;
  logic       valid_r = 1'b0;
  assign byte_o  = byte_r;
  assign valid_o = valid_r;
  // ****************************
  // hold each byte until taken
  // ****************************
  always @(posedge clk_i) begin
    if (valid_r && rdy_i) begin
      valid_r <= 1'b0;
      byte_r  <= ~byte_r;
    end else if (!valid_r && go_i && ($random(seed) % 2 != 0)) begin
      valid_r <= 1'b1;
      byte_r  <= $random(seed);
    end else if (!valid_r) begin
      byte_r  <= ~byte_r;
    end
  end
endmodule : urd_src_model
